// ---- fcpd_pkg.sv ----
package fcpd_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 250;
  // Head settle and release intervals are given in milliseconds.
  localparam int MS_CYCLES     = CLK_MHZ * 1000;

  // ---------------------------------------------------------------
  // Sector sizes
  // ---------------------------------------------------------------
  localparam int          BASE_SECTOR_BYTES = 128;
  localparam logic [2:0]  MAX_SIZE_CODE     = 3'h7;
  localparam int          GAP2_NORMAL       = 22;
  localparam int          GAP2_PERP         = 41;

  // ---------------------------------------------------------------
  // Configuration reset values
  // ---------------------------------------------------------------
  localparam logic       RST_FIFO_DISABLE_LOW = 1'h1;
  localparam logic [3:0] RST_FIFO_THRESHOLD   = 4'h0;
  localparam logic [7:0] RST_PRECOMP_TRACK    = 8'h00;

  // ---------------------------------------------------------------
  // Command parameters
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       is_write;
    logic       has_cylinder;
    logic       multi_track_flag;
    logic       density_select;
    logic       head_select;
    logic [7:0] cylinder;
    logic [7:0] first_sector;
    logic [7:0] last_sector_of_track;
    logic [7:0] size_code;
    logic [7:0] inter_sector_gap_length;
    logic [7:0] short_sector_length;
  } fcpd_cmd_s;

  typedef struct packed {
    logic       fifo_disable_low;
    logic [3:0] fifo_threshold;
    logic [7:0] precomp_start_track;
  } fcpd_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SEEK   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_XFER   = 3'b011,
    ST_PAD    = 3'b100
  } fcpd_state_e;

  // Sector length in bytes from the size code
  function automatic logic [14:0] sector_bytes(input logic [2:0] code);
    sector_bytes = 15'(BASE_SECTOR_BYTES) << code;
  endfunction

endpackage

// ---- fcpd_interval_timer.sv ----
`timescale 1ns/1ps
module fcpd_interval_timer
  import fcpd_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] ms,
  output logic            done
);
  if (MS_CYC < 1) begin : g_bad_ms_cyc
    $error("MS_CYC must be positive");
  end

  logic [31:0] sub;
  logic [7:0]  left;
  logic        run;
  logic [31:0] next_sub;
  logic [7:0]  next_left;
  logic        next_run;
  logic        next_done;

  always_comb begin
    next_sub  = sub;
    next_left = left;
    next_run  = run;
    next_done = 1'b0;
    if (start) begin
      next_sub  = 32'h0;
      next_left = ms;
      next_run  = 1'b1;
    end else if (run) begin
      if (left == 8'h0) begin
        next_run  = 1'b0;
        next_done = 1'b1;
      end else if (sub == 32'(MS_CYC - 1)) begin
        next_sub  = 32'h0;
        next_left = left - 8'h1;
      end else begin
        next_sub = sub + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sub  <= 32'h0;
      left <= 8'h0;
      run  <= 1'b0;
      done <= 1'b0;
    end else begin
      sub  <= next_sub;
      left <= next_left;
      run  <= next_run;
      done <= next_done;
    end
  end
endmodule

// ---- fcpd_top.sv ----
`timescale 1ns/1ps
module fcpd_top
  import fcpd_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST_N,
  // Command
  input  wire logic       CMD_START,
  input  wire fcpd_cmd_s  CMD,
  input  wire logic       IMPLIED_SEEK_ENABLE,
  input  wire logic       PERPENDICULAR_MODE,
  input  wire logic [7:0] GAP_PARAM,
  input  wire logic [7:0] HEAD_SETTLE_TIME,
  input  wire logic [7:0] HEAD_RELEASE_TIME,
  // Configuration
  input  wire logic       CFG_WRITE,
  input  wire fcpd_cfg_s  CFG_IN,
  input  wire logic       LOCK_WRITE,
  input  wire logic       LOCK_IN,
  input  wire logic       SOFT_RESET,
  // Drive side
  input  wire logic       SEEK_DONE,
  input  wire logic       BYTE_STROBE,
  output logic            SEEK_REQ,
  output logic [7:0]      SEEK_CYLINDER,
  output logic            HEAD_LOADED,
  output logic            ACCESS_ACTIVE,
  output logic            ID_HEAD,
  output logic [7:0]      ID_SECTOR,
  output logic            DENSITY_MFM,
  output logic [7:0]      GAP2_LENGTH,
  output logic [7:0]      GAP3_LENGTH,
  output logic [14:0]     SECTOR_LENGTH,
  output logic            HOST_PASS,
  output logic            WRITE_ZERO,
  // Status
  output fcpd_cfg_s       CFG,
  output logic            LOCKED,
  output logic            CMD_DONE
);

  // -------------------------------------------------------------
  // Parameter check
  // -------------------------------------------------------------
  // A zero prescale would stretch each head-timer millisecond to 2^32 cycles
  if (MS_CYC < 1) begin : g_bad_ms_cyc
    $error("MS_CYC must be at least one");
  end

  // -------------------------------------------------------------
  // Configuration with lock
  // -------------------------------------------------------------
  fcpd_cfg_s next_cfg;
  logic      next_locked;

  always_comb begin
    next_cfg    = CFG;
    next_locked = LOCKED;
    if (LOCK_WRITE) begin
      next_locked = LOCK_IN;
    end
    if (CFG_WRITE) begin
      next_cfg = CFG_IN;
    end else if (SOFT_RESET && !LOCKED) begin
      next_cfg.fifo_disable_low    = RST_FIFO_DISABLE_LOW;
      next_cfg.fifo_threshold      = RST_FIFO_THRESHOLD;
      next_cfg.precomp_start_track = RST_PRECOMP_TRACK;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      CFG.fifo_disable_low    <= RST_FIFO_DISABLE_LOW;
      CFG.fifo_threshold      <= RST_FIFO_THRESHOLD;
      CFG.precomp_start_track <= RST_PRECOMP_TRACK;
      LOCKED                  <= 1'b0;
    end else begin
      CFG    <= next_cfg;
      LOCKED <= next_locked;
    end
  end

  // -------------------------------------------------------------
  // Head timers
  // -------------------------------------------------------------
  logic settle_start;
  logic settle_done;
  logic release_start;
  logic release_done;

  fcpd_interval_timer #(.MS_CYC(MS_CYC)) u_settle (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .start (settle_start),
    .ms    (HEAD_SETTLE_TIME),
    .done  (settle_done)
  );

  fcpd_interval_timer #(.MS_CYC(MS_CYC)) u_release (
    .clk   (CLOCK),
    .rst_n (RST_N),
    .start (release_start),
    .ms    (HEAD_RELEASE_TIME),
    .done  (release_done)
  );

  // -------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------
  fcpd_state_e state;
  fcpd_state_e next_state;
  fcpd_cmd_s   cmd;
  fcpd_cmd_s   next_cmd;
  logic [14:0] byte_cnt;
  logic [14:0] next_byte_cnt;
  logic [14:0] phys_len;
  logic [14:0] xfer_len;
  logic        next_seek_req;
  logic [7:0]  next_seek_cyl;
  logic        next_head_loaded;
  logic        next_id_head;
  logic [7:0]  next_id_sector;
  logic        next_cmd_done;
  logic        last_byte;

  // Sizes saturate at the largest code; bad combos are not guarded
  function automatic logic [14:0] phys_bytes(input logic [7:0] code);
    phys_bytes = sector_bytes(code > 8'(MAX_SIZE_CODE) ?
                              MAX_SIZE_CODE : code[2:0]);
  endfunction

  always_comb begin
    phys_len = phys_bytes(cmd.size_code);
    if (cmd.size_code == 8'h00) begin
      xfer_len = {7'h0, cmd.short_sector_length};
      // Short length never runs past the physical sector
      if (xfer_len > phys_len) xfer_len = phys_len;
    end else begin
      xfer_len = phys_len;
    end
  end

  assign last_byte = BYTE_STROBE && (byte_cnt == phys_len - 15'h1);

  always_comb begin
    next_state       = state;
    next_cmd         = cmd;
    next_byte_cnt    = byte_cnt;
    next_seek_req    = 1'b0;
    next_seek_cyl    = SEEK_CYLINDER;
    next_head_loaded = HEAD_LOADED;
    next_id_head     = ID_HEAD;
    next_id_sector   = ID_SECTOR;
    next_cmd_done    = 1'b0;
    settle_start     = 1'b0;
    release_start    = 1'b0;
    // A new access must not lose its head to an older release timer
    if (release_done && state != ST_XFER && state != ST_PAD) begin
      next_head_loaded = 1'b0;
    end
    unique case (state)
      ST_IDLE: begin
        if (CMD_START) begin
          next_cmd       = CMD;
          next_byte_cnt  = 15'h0;
          next_id_head   = CMD.head_select;
          next_id_sector = CMD.first_sector;
          if (IMPLIED_SEEK_ENABLE && CMD.has_cylinder) begin
            next_seek_req = 1'b1;
            next_seek_cyl = CMD.cylinder;
            next_state    = ST_SEEK;
          end else if (HEAD_LOADED && !release_done) begin
            // Head still loaded, so no settle wait
            next_state = ST_XFER;
          end else begin
            settle_start = 1'b1;
            next_state   = ST_SETTLE;
          end
        end
      end
      ST_SEEK: begin
        if (SEEK_DONE) begin
          settle_start = 1'b1;
          next_state   = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        next_head_loaded = 1'b1;
        if (settle_done) next_state = ST_XFER;
      end
      ST_XFER, ST_PAD: begin
        if (BYTE_STROBE) next_byte_cnt = byte_cnt + 15'h1;
        if (BYTE_STROBE && byte_cnt == xfer_len - 15'h1 &&
            xfer_len != phys_len) begin
          next_state = ST_PAD;
        end
        if (last_byte) begin
          next_byte_cnt = 15'h0;
          if (ID_SECTOR != cmd.last_sector_of_track) begin
            next_id_sector = ID_SECTOR + 8'h1;
            next_state     = ST_XFER;
          end else if (cmd.multi_track_flag && !ID_HEAD) begin
            next_id_head   = 1'b1;
            next_id_sector = 8'h01;
            next_state     = ST_XFER;
          end else begin
            release_start = 1'b1;
            next_cmd_done = 1'b1;
            next_state    = ST_IDLE;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state         <= ST_IDLE;
      cmd           <= '0;
      byte_cnt      <= 15'h0;
      SEEK_REQ      <= 1'b0;
      SEEK_CYLINDER <= 8'h00;
      HEAD_LOADED   <= 1'b0;
      ID_HEAD       <= 1'b0;
      ID_SECTOR     <= 8'h00;
      CMD_DONE      <= 1'b0;
    end else begin
      state         <= next_state;
      cmd           <= next_cmd;
      byte_cnt      <= next_byte_cnt;
      SEEK_REQ      <= next_seek_req;
      SEEK_CYLINDER <= next_seek_cyl;
      HEAD_LOADED   <= next_head_loaded;
      ID_HEAD       <= next_id_head;
      ID_SECTOR     <= next_id_sector;
      CMD_DONE      <= next_cmd_done;
    end
  end

  // -------------------------------------------------------------
  // Format outputs
  // -------------------------------------------------------------
  logic        next_access_active;
  logic        next_density_mfm;
  logic [7:0]  next_gap2_length;
  logic [7:0]  next_gap3_length;
  logic [14:0] next_sector_length;
  logic        next_host_pass;
  logic        next_write_zero;

  always_comb begin
    next_access_active = (next_state == ST_XFER) || (next_state == ST_PAD);
    next_density_mfm   = next_cmd.density_select;
    next_gap2_length   = PERPENDICULAR_MODE ? GAP_PARAM
                                            : 8'(GAP2_NORMAL);
    next_gap3_length   = next_cmd.inter_sector_gap_length;
    next_sector_length = phys_bytes(next_cmd.size_code);
    // Remainder of a short sector is read but held back from the host
    next_host_pass     = (next_state == ST_XFER);
    next_write_zero    = (next_state == ST_PAD) &&
                         next_cmd.is_write;
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ACCESS_ACTIVE <= 1'b0;
      DENSITY_MFM   <= 1'b0;
      GAP2_LENGTH   <= 8'(GAP2_NORMAL);
      GAP3_LENGTH   <= 8'h00;
      SECTOR_LENGTH <= 15'h0;
      HOST_PASS     <= 1'b0;
      WRITE_ZERO    <= 1'b0;
    end else begin
      ACCESS_ACTIVE <= next_access_active;
      DENSITY_MFM   <= next_density_mfm;
      GAP2_LENGTH   <= next_gap2_length;
      GAP3_LENGTH   <= next_gap3_length;
      SECTOR_LENGTH <= next_sector_length;
      HOST_PASS     <= next_host_pass;
      WRITE_ZERO    <= next_write_zero;
    end
  end

endmodule

// ---- fcpd_checker.sv ----
`timescale 1ns/1ps
module fcpd_checker
  import fcpd_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  // Clock, reset and inputs
  input wire logic        CLOCK,
  input wire logic        RST_N,
  input wire fcpd_cmd_s   CMD,
  input wire logic        IMPLIED_SEEK_ENABLE,
  input wire logic        PERPENDICULAR_MODE,
  input wire logic [7:0]  GAP_PARAM,
  input wire logic [7:0]  HEAD_SETTLE_TIME,
  input wire logic [7:0]  HEAD_RELEASE_TIME,
  input wire logic        CFG_WRITE,
  input wire logic        SOFT_RESET,
  // Outputs watched
  input wire logic        SEEK_REQ,
  input wire logic        HEAD_LOADED,
  input wire logic        ACCESS_ACTIVE,
  input wire logic        ID_HEAD,
  input wire logic [7:0]  ID_SECTOR,
  input wire logic        DENSITY_MFM,
  input wire logic [7:0]  GAP2_LENGTH,
  input wire logic [7:0]  GAP3_LENGTH,
  input wire logic [14:0] SECTOR_LENGTH,
  input wire fcpd_cfg_s   CFG,
  input wire logic        LOCKED,
  input wire logic        CMD_DONE
);
  // ------------------------------------------
  // Interval counters, saturating
  // ------------------------------------------
  logic [31:0] load_cnt;
  logic [31:0] rel_cnt;
  logic        hl_q;
  logic [31:0] next_load_cnt;
  logic [31:0] next_rel_cnt;
  always_comb begin
    next_load_cnt = (HEAD_LOADED && !hl_q) ? 32'h0 :
                    load_cnt + 32'(load_cnt != 32'hffffffff);
    next_rel_cnt  = CMD_DONE ? 32'h0 :
                    rel_cnt + 32'(rel_cnt != 32'hffffffff);
  end
  always_ff @(posedge CLOCK) begin
    hl_q     <= RST_N && HEAD_LOADED;
    load_cnt <= RST_N ? next_load_cnt : 32'h0;
    rel_cnt  <= RST_N ? next_rel_cnt : 32'h0;
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  sequence s_access_start;
    $rose(ACCESS_ACTIVE);
  endsequence
  a_seek_one_cycle: assert property (SEEK_REQ |=> !SEEK_REQ)
    else $error("seek request longer than one cycle");
  a_seek_only_enabled: assert property ($rose(SEEK_REQ) |-> IMPLIED_SEEK_ENABLE)
    else $error("seek without implied seek enable");
  a_settle_wait: assert property (s_access_start |->
    load_cnt + 32'h1 >= 32'(HEAD_SETTLE_TIME) * 32'(MS_CYC))
    else $error("access before head settle interval");
  a_release_wait: assert property ($fell(HEAD_LOADED) |->
    rel_cnt + 32'h1 >= 32'(HEAD_RELEASE_TIME) * 32'(MS_CYC))
    else $error("head released too early");
  a_gap_two: assert property (ACCESS_ACTIVE |-> GAP2_LENGTH ==
    (PERPENDICULAR_MODE ? GAP_PARAM : 8'(GAP2_NORMAL)))
    else $error("gap 2 length wrong");
  a_gap_three: assert property (ACCESS_ACTIVE |->
    GAP3_LENGTH == CMD.inter_sector_gap_length)
    else $error("gap 3 length wrong");
  a_density_sel: assert property (ACCESS_ACTIVE |->
    DENSITY_MFM == CMD.density_select)
    else $error("density select wrong");
  a_sector_in_range: assert property (ACCESS_ACTIVE |->
    ID_SECTOR <= CMD.last_sector_of_track)
    else $error("sector past end of track");
  a_sector_len: assert property (ACCESS_ACTIVE |->
    SECTOR_LENGTH == (15'h0080 << CMD.size_code[2:0]))
    else $error("sector length wrong");
  a_head_single: assert property (ACCESS_ACTIVE && !CMD.multi_track_flag
    |-> ID_HEAD == CMD.head_select)
    else $error("head number wrong");
  a_lock_keeps: assert property (SOFT_RESET && LOCKED && !CFG_WRITE
    |=> CFG == $past(CFG))
    else $error("locked configuration lost");
  a_unlock_resets: assert property (SOFT_RESET && !LOCKED && !CFG_WRITE
    |=> CFG == {RST_FIFO_DISABLE_LOW, RST_FIFO_THRESHOLD,
                RST_PRECOMP_TRACK})
    else $error("configuration not restored");
endmodule

// ---- fcpd_drive_model.sv ----
`timescale 1ns/1ps
module fcpd_drive_model (
  // Clock and requests
  input  wire logic CLOCK,
  input  wire logic RST_N,
  input  wire logic SEEK_REQ,
  input  wire logic slow,
  // Drive answers
  output logic      SEEK_DONE,
  output logic      BYTE_STROBE
);
  logic [3:0] wait_cnt;
  // Disk keeps turning, so bytes pass every other cycle even when idle
  always @(negedge CLOCK) begin
    BYTE_STROBE <= RST_N && !BYTE_STROBE;
    SEEK_DONE   <= RST_N && wait_cnt == 4'h1;
    if (!RST_N)
      wait_cnt <= 4'h0;
    else if (SEEK_REQ)
      wait_cnt <= slow ? 4'h9 : 4'h2;
    else if (wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
  end
endmodule

// ---- tb_floppy_command_parameter_decode.sv ----
`timescale 1ns/1ps
module tb_floppy_command_parameter_decode;
  import fcpd_pkg::*;
  localparam int MSC = 4;
  logic        CLOCK = 1'b0;
  logic        RST_N, CMD_START, IMPLIED_SEEK_ENABLE, PERPENDICULAR_MODE;
  logic        CFG_WRITE, LOCK_WRITE, LOCK_IN, SOFT_RESET, slow;
  logic [7:0]  GAP_PARAM, HEAD_SETTLE_TIME, HEAD_RELEASE_TIME;
  fcpd_cmd_s   CMD;
  fcpd_cfg_s   CFG_IN, CFG;
  logic        SEEK_DONE, BYTE_STROBE, SEEK_REQ, HEAD_LOADED, ACCESS_ACTIVE;
  logic        ID_HEAD, DENSITY_MFM, HOST_PASS, WRITE_ZERO, LOCKED, CMD_DONE;
  logic [7:0]  SEEK_CYLINDER, ID_SECTOR, GAP2_LENGTH, GAP3_LENGTH;
  logic [14:0] SECTOR_LENGTH;
  int          miscompares, check_count, n_pass, n_zero, n_seek, n_head1;
  int          n_drop;

  fcpd_top #(.MS_CYC(MSC)) i_fcpd_top (.CLOCK, .RST_N, .CMD_START, .CMD,
    .IMPLIED_SEEK_ENABLE, .PERPENDICULAR_MODE, .GAP_PARAM, .HEAD_SETTLE_TIME,
    .HEAD_RELEASE_TIME, .CFG_WRITE, .CFG_IN, .LOCK_WRITE, .LOCK_IN,
    .SOFT_RESET, .SEEK_DONE, .BYTE_STROBE, .SEEK_REQ, .SEEK_CYLINDER,
    .HEAD_LOADED, .ACCESS_ACTIVE, .ID_HEAD, .ID_SECTOR, .DENSITY_MFM,
    .GAP2_LENGTH, .GAP3_LENGTH, .SECTOR_LENGTH, .HOST_PASS, .WRITE_ZERO,
    .CFG, .LOCKED, .CMD_DONE);
  fcpd_drive_model i_fcpd_drive_model (.CLOCK, .RST_N, .SEEK_REQ, .slow,
    .SEEK_DONE, .BYTE_STROBE);

  initial forever #2 CLOCK = ~CLOCK;
  // Byte and cycle tallies per command, taken on the edge the design sees
  always @(posedge CLOCK) begin
    n_pass += int'(BYTE_STROBE && HOST_PASS);
    n_zero += int'(BYTE_STROBE && WRITE_ZERO);
    n_seek += int'(SEEK_REQ === 1'b1);
    n_head1 += int'(ACCESS_ACTIVE && ID_HEAD);
    n_drop += int'(ACCESS_ACTIVE && !HEAD_LOADED);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge CLOCK);
    s = 1'b0;
  endtask
  task automatic run(input fcpd_cmd_s c, input int sk, input int pa,
                     input int ze);
    CMD = c;
    n_pass = 0;
    n_zero = 0;
    n_seek = 0;
    n_head1 = 0;
    n_drop = 0;
    pulse(CMD_START);
    for (int i = 0; i < 4000 && CMD_DONE !== 1'b1; i++)
      @(negedge CLOCK);
    if (CMD_DONE !== 1'b1) begin
      miscompares++;
      wrap_up();
    end
    @(negedge CLOCK);
    chk(16'(n_seek), 16'(sk));
    chk(16'(n_pass), 16'(pa));
    chk(16'(n_zero), 16'(ze));
    chk(16'(n_drop), 16'h0000);
  endtask

  task automatic t_lock;
    CFG_IN = '{1'b0, 4'h9, 8'h40};
    pulse(CFG_WRITE);
    LOCK_IN = 1'b1;
    pulse(LOCK_WRITE);
    chk(16'(LOCKED), 16'h0001);
    pulse(SOFT_RESET);
    @(negedge CLOCK);
    chk(16'(CFG), 16'h0940);
    LOCK_IN = 1'b0;
    pulse(LOCK_WRITE);
    chk(16'(LOCKED), 16'h0000);
    pulse(SOFT_RESET);
    @(negedge CLOCK);
    chk(16'(CFG), 16'h1000);
  endtask
  // Seek, perpendicular gap, two 256-byte sectors on side 1
  task automatic t_seek_read;
    int n;
    IMPLIED_SEEK_ENABLE = 1'b1;
    PERPENDICULAR_MODE = 1'b1;
    GAP_PARAM = 8'h2a;
    slow = 1'b1;
    run('{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 8'h05, 8'h01, 8'h02, 8'h01,
          8'h1b, 8'hff}, 1, 512, 0);
    chk(16'(SEEK_CYLINDER), 16'h0005);
    chk(16'(ID_SECTOR), 16'h0002);
    chk(16'(ID_HEAD), 16'h0001);
    for (n = 0; n < 100 && HEAD_LOADED !== 1'b0; n++)
      @(negedge CLOCK);
    chk(16'(n >= 6 && n <= 12), 16'h0001);
  endtask
  // No seek, short write sector spanning both heads
  task automatic t_multi_short;
    IMPLIED_SEEK_ENABLE = 1'b0;
    PERPENDICULAR_MODE = 1'b0;
    slow = 1'b0;
    run('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h03, 8'h01, 8'h01, 8'h00,
          8'h07, 8'h14}, 0, 40, 216);
    chk(16'(n_head1 > 0), 16'h0001);
  endtask
  // Next command while the head is still loaded: no settle, no unload
  task automatic t_back_to_back;
    run('{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h06, 8'h03, 8'h03, 8'h02,
          8'h36, 8'hff}, 0, 512, 0);
    chk(16'(ID_SECTOR), 16'h0003);
    chk(16'(ID_HEAD), 16'h0000);
    chk(16'(SECTOR_LENGTH), 16'h0200);
    chk(16'(GAP3_LENGTH), 16'h0036);
    chk(16'(DENSITY_MFM), 16'h0001);
  endtask

  initial begin
    {RST_N, CMD_START, CFG_WRITE, LOCK_WRITE, LOCK_IN, SOFT_RESET} = '0;
    {IMPLIED_SEEK_ENABLE, PERPENDICULAR_MODE, slow} = '0;
    GAP_PARAM = 8'h00;
    HEAD_SETTLE_TIME = 8'h01;
    HEAD_RELEASE_TIME = 8'h02;
    CMD = '0;
    CFG_IN = '0;
    miscompares = 0;
    check_count = 0;
    repeat (2) @(negedge CLOCK);
    RST_N = 1'b1;
    chk(16'(CFG), 16'h1000);
    chk(16'(GAP2_LENGTH), 16'h0016);
    t_lock();
    t_seek_read();
    t_multi_short();
    t_back_to_back();
    wrap_up();
  end
endmodule

bind fcpd_top fcpd_checker #(.MS_CYC(MS_CYC)) i_fcpd_checker (.CLOCK,
  .RST_N, .CMD, .IMPLIED_SEEK_ENABLE, .PERPENDICULAR_MODE, .GAP_PARAM,
  .HEAD_SETTLE_TIME, .HEAD_RELEASE_TIME, .CFG_WRITE, .SOFT_RESET,
  .SEEK_REQ, .HEAD_LOADED, .ACCESS_ACTIVE, .ID_HEAD, .ID_SECTOR,
  .DENSITY_MFM, .GAP2_LENGTH, .GAP3_LENGTH, .SECTOR_LENGTH, .CFG,
  .LOCKED, .CMD_DONE);
